// ### rtl/mmbd_map.svh
`ifndef MMBD_MAP_SVH
`define MMBD_MAP_SVH
// ****************************************
// Memory map constants
// ****************************************
`define MMBD_PC_W 13
`define MMBD_IMPL_AW 11
`define MMBD_WORD_W 14
`define MMBD_RESET_VEC 13'h0000
`define MMBD_INT_VEC 13'h0004
`define MMBD_STATUS_ADDR 7'h03
`define MMBD_BANK_HI_POS 6
`define MMBD_BANK_LO_POS 5
`define MMBD_INDIRECT_ADDR 7'h00
`define MMBD_PTR_ADDR 7'h04
`define MMBD_SFR_TOP 7'h1f
`define MMBD_GPR_BASE 7'h20
`define MMBD_SHARED_BASE 7'h70
`define MMBD_BANK_TOP 7'h7f
`define MMBD_GPR_WORDS 128
`define MMBD_UNIMPL_DATA 8'h00
`endif

// ### rtl/mmbd_pkg.sv
package mmbd_pkg;
  typedef enum logic [1:0] {
    MMBD_REGION_SFR = 2'b00,
    MMBD_REGION_GPR = 2'b01,
    MMBD_REGION_NONE = 2'b10
  } mmbd_region_t;
  // Decoded data address
  typedef struct packed {
    logic [8:0] full_addr;
    mmbd_region_t region;
    logic [6:0] gpr_index;
    logic [4:0] sfr_index;
  } mmbd_decode_t;
endpackage : mmbd_pkg

// ### rtl/mmbd_data_decode.sv
`timescale 1ns/10ps
`include "mmbd_map.svh"
module mmbd_data_decode
  import mmbd_pkg::*;
(
  input wire logic [1:0] i_bank_select_field,
  input wire logic [6:0] i_local_addr,
  output mmbd_decode_t o_decode
);
  // ****************************************
  // Bank and region decode
  // ****************************************
  always_comb begin
    o_decode.full_addr = {i_bank_select_field, i_local_addr};
    o_decode.sfr_index = i_local_addr[4:0];
    o_decode.gpr_index = 7'h00;
    if (i_local_addr <= `MMBD_SFR_TOP) begin
      o_decode.region = MMBD_REGION_SFR;
    end else if (i_local_addr >= `MMBD_SHARED_BASE) begin
      o_decode.region = MMBD_REGION_GPR;
      o_decode.gpr_index = {3'h0, i_local_addr[3:0]} + 7'h60;
    end else if (i_bank_select_field == 2'b00) begin
      o_decode.region = MMBD_REGION_GPR;
      o_decode.gpr_index = i_local_addr - `MMBD_GPR_BASE;
    end else begin
      o_decode.region = MMBD_REGION_NONE;
    end
  end
endmodule : mmbd_data_decode

// ### rtl/mmbd_memory_map_bank_decode.sv
`timescale 1ns/10ps
`include "mmbd_map.svh"
// Overview of operation
// - Thirteen bit program counter, 8K word space
// - Only 2K words fitted, addresses wrap
// - Reset loads program counter with zero
// - Interrupt redirects next fetch to 0004h
// - Two status bits select one of four banks for direct access; indirect uses status bit 7 and pointer bit 7
// - Each bank spans 128 local locations
// - Lowest bank locations are special registers
// - Locations above them are static RAM in bank 0; other banks fit only the shared 70h-7Fh
// - Every bank holds special registers
// - Common registers mirrored across banks
// - Direct or indirect pointer addressing
// - Fetch and data access run concurrently
// - Unimplemented data locations read zero
module mmbd_memory_map_bank_decode
  import mmbd_pkg::*;
#(
  parameter int PC_W = `MMBD_PC_W,
  parameter int IMPL_AW = `MMBD_IMPL_AW
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_fetch_adv,
  input wire logic i_branch,
  input wire logic [PC_W-1:0] i_branch_addr,
  input wire logic i_int_accept,
  input wire logic i_data_req,
  input wire logic i_data_we,
  input wire logic i_indirect,
  input wire logic [6:0] i_direct_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_sfr_rdata,
  output logic [PC_W-1:0] o_pc,
  output logic [IMPL_AW-1:0] o_prog_addr,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_sfr_sel,
  output logic o_sfr_we,
  output logic [4:0] o_sfr_index,
  output logic [1:0] o_bank_select_field,
  output logic [7:0] o_indirect_pointer
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [IMPL_AW-1:0] prog_addr;
    logic [7:0] rdata;
    logic rvalid;
    logic sfr_sel;
    logic sfr_we;
    logic [4:0] sfr_index;
    logic [7:0] status;
    logic [7:0] indirect_pointer;
  } mmbd_state_t;

  mmbd_state_t st_reg;
  mmbd_state_t st_next;
  logic [7:0] gpr_mem [`MMBD_GPR_WORDS];
  logic [6:0] local_addr;
  logic [1:0] bank_sel;
  mmbd_decode_t dec;
  logic is_status;
  logic is_ptr;
  logic is_ind_self;
  logic gpr_we;

  // ****************************************
  // Address source selection
  // ****************************************
  always_comb begin
    bank_sel = {st_reg.status[`MMBD_BANK_HI_POS], st_reg.status[`MMBD_BANK_LO_POS]};
    local_addr = i_direct_addr;
    if (i_indirect) begin
      bank_sel = {st_reg.status[7], st_reg.indirect_pointer[7]};
      local_addr = st_reg.indirect_pointer[6:0];
    end
  end

  // Region and bank decode of the chosen address
  mmbd_data_decode u_decode (
    .i_bank_select_field(bank_sel),
    .i_local_addr(local_addr),
    .o_decode(dec)
  );

  // Locally held registers and ram write strobe
  assign is_status = (dec.region == MMBD_REGION_SFR) && (local_addr == `MMBD_STATUS_ADDR);
  assign is_ptr = (dec.region == MMBD_REGION_SFR) && (local_addr == `MMBD_PTR_ADDR);
  assign is_ind_self = (dec.region == MMBD_REGION_SFR) && (local_addr == `MMBD_INDIRECT_ADDR);
  assign gpr_we = i_ce && i_data_req && i_data_we && (dec.region == MMBD_REGION_GPR);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.sfr_we = 1'b0;
    st_next.sfr_sel = 1'b0;
    // Program counter, separate from data path
    if (i_int_accept) begin
      st_next.pc = PC_W'(`MMBD_INT_VEC);
    end else if (i_branch) begin
      st_next.pc = i_branch_addr;
    end else if (i_fetch_adv) begin
      st_next.pc = st_reg.pc + PC_W'(1);
    end
    st_next.prog_addr = st_next.pc[IMPL_AW-1:0];
    // Data access
    if (i_data_req) begin
      st_next.rvalid = ~i_data_we;
      st_next.sfr_index = dec.sfr_index;
      st_next.rdata = `MMBD_UNIMPL_DATA;
      if (is_status) begin
        st_next.rdata = st_reg.status;
        if (i_data_we) st_next.status = i_wdata;
      end else if (is_ptr) begin
        st_next.rdata = st_reg.indirect_pointer;
        if (i_data_we) st_next.indirect_pointer = i_wdata;
      end else if (is_ind_self) begin
        st_next.rdata = `MMBD_UNIMPL_DATA;
      end else if (dec.region == MMBD_REGION_SFR) begin
        st_next.sfr_sel = 1'b1;
        st_next.sfr_we = i_data_we;
      end else if (dec.region == MMBD_REGION_GPR) begin
        st_next.rdata = gpr_mem[dec.gpr_index];
      end
    end
    if (st_reg.sfr_sel && st_reg.rvalid) begin
      st_next.rdata = i_sfr_rdata;
    end
  end

  // ****************************************
  // Registers and static RAM
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // Static RAM write port, frozen with the clock enable
  always_ff @(posedge i_sys_clk) begin
    if (gpr_we) begin
      gpr_mem[dec.gpr_index] <= i_wdata;
    end
  end

  // Outputs straight from the state register
  assign o_pc = st_reg.pc;
  assign o_prog_addr = st_reg.prog_addr;
  assign o_rdata = st_reg.rdata;
  assign o_rvalid = st_reg.rvalid;
  assign o_sfr_sel = st_reg.sfr_sel;
  assign o_sfr_we = st_reg.sfr_we;
  assign o_sfr_index = st_reg.sfr_index;
  assign o_bank_select_field = {st_reg.status[`MMBD_BANK_HI_POS], st_reg.status[`MMBD_BANK_LO_POS]};
  assign o_indirect_pointer = st_reg.indirect_pointer;

  // ****************************************
  // Checks
  // ****************************************
  // Program side, reset first; the step, hold and fetch beside data checks use $past history
  reset_vector_a: assert property (@(posedge i_sys_clk) i_rst |=> o_pc == '0)
    else $error("pc not zero after reset");
  int_vector_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_int_accept && i_ce |=> o_pc == PC_W'(`MMBD_INT_VEC))
    else $error("interrupt vector missed");
  prog_wrap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_prog_addr == o_pc[IMPL_AW-1:0])
    else $error("program address not wrapped");
  pc_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_fetch_adv && !i_branch && !i_int_accept |=> o_pc == $past(o_pc) + PC_W'(1))
    else $error("pc did not step");
  pc_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_ce |=> o_pc == $past(o_pc))
    else $error("pc moved while frozen");
  fetch_beside_data_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_data_req && !i_data_we && i_fetch_adv && !i_branch && !i_int_accept
    |=> o_rvalid && o_pc == $past(o_pc) + PC_W'(1))
    else $error("fetch stalled by data access");
  // Data side, bank and address forming
  bank_full_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_indirect |-> dec.full_addr == {o_bank_select_field, i_direct_addr})
    else $error("direct address mis-formed");
  local_span_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    dec.full_addr[6:0] == local_addr)
    else $error("local address lost");
  indirect_bank_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_indirect |-> dec.full_addr == {st_reg.status[7], o_indirect_pointer})
    else $error("indirect address mis-formed");
  ptr_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_data_req && i_data_we && is_ptr |=> o_indirect_pointer == $past(i_wdata))
    else $error("pointer write lost");
  bank_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_data_req && i_data_we && is_status
    |=> o_bank_select_field == 2'($past(i_wdata) >> `MMBD_BANK_LO_POS))
    else $error("bank select write lost");
  // Data side, regions
  sfr_low_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    local_addr < 7'h20 |-> dec.region == MMBD_REGION_SFR)
    else $error("low address not sfr");
  sfr_strobe_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_data_req && dec.region == MMBD_REGION_SFR
    && !is_status && !is_ptr && !is_ind_self
    |=> o_sfr_sel && o_sfr_we == $past(i_data_we)
    && o_sfr_index == 5'($past(local_addr)))
    else $error("peripheral strobe missed");
  sfr_capture_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && o_sfr_sel && o_rvalid |=> o_rdata == $past(i_sfr_rdata))
    else $error("peripheral read data not taken");
  status_every_bank_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    local_addr == `MMBD_STATUS_ADDR |-> dec.region == MMBD_REGION_SFR)
    else $error("bank without special registers");
  gpr_above_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    bank_sel == 2'b00 && local_addr >= `MMBD_GPR_BASE |-> dec.region == MMBD_REGION_GPR)
    else $error("bank zero ram not mapped");
  unimpl_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_data_req && !i_data_we && dec.region == MMBD_REGION_NONE
    |=> o_rvalid && o_rdata == 8'h00)
    else $error("unimplemented read not zero");
  mirror_gpr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    local_addr >= 7'h70 |-> dec.region == MMBD_REGION_GPR)
    else $error("shared window not mapped");
endmodule : mmbd_memory_map_bank_decode

// ### tb/mmbd_sfr_model.sv
`timescale 1ns/10ps
// ****************************************
// Peripheral register responder
// ****************************************
module mmbd_sfr_model (
  input wire logic i_sys_clk,
  input wire logic i_sel,
  input wire logic [4:0] i_index,
  output logic [7:0] o_rdata
);
  logic [4:0] last_reg;
  logic hold_reg;
  // Remember the selected index for one hold cycle
  always_ff @(posedge i_sys_clk) begin
    hold_reg <= i_sel;
    if (i_sel) begin
      last_reg <= i_index;
    end
  end
  // Pattern per index; scrambled once the hold has run out
  assign o_rdata = i_sel ? (8'h5a ^ {3'h0, i_index}) :
    hold_reg ? (8'h5a ^ {3'h0, last_reg}) : ~(8'h5a ^ {3'h0, last_reg});
endmodule : mmbd_sfr_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t mismatch got %h want %h", $time, a, b); end end
// ****************************************
// Bench for the memory map decoder
// ****************************************
module tb_top;
  import mmbd_pkg::*;
  logic clk = 0, rst = 1, ce = 1, adv = 0, br = 0, intr = 0, req = 0, we = 0, ind = 0;
  logic [12:0] baddr = 0, pc;
  logic [6:0] daddr = 0;
  logic [7:0] wd = 0, sfr_d, rdata, ptr_o;
  logic [10:0] paddr;
  logic rv, ssel, swe;
  logic [4:0] sidx;
  logic [1:0] bsel;
  logic [31:0] seed = 32'h8cc7, r, rp;
  int failures = 0, check_count = 0, pc_m = 0, st = 0, ptr = 0, mem[128];
  bit go = 0, rce = 0;
  // Clock, 25 ns period
  always #12.5 clk = ~clk;
  mmbd_memory_map_bank_decode i_mmbd_memory_map_bank_decode (.i_sys_clk(clk), .i_rst(rst),
    .i_ce(ce), .i_fetch_adv(adv), .i_branch(br), .i_branch_addr(baddr), .i_int_accept(intr),
    .i_data_req(req), .i_data_we(we), .i_indirect(ind), .i_direct_addr(daddr), .i_wdata(wd),
    .i_sfr_rdata(sfr_d), .o_pc(pc), .o_prog_addr(paddr), .o_rdata(rdata), .o_rvalid(rv),
    .o_sfr_sel(ssel), .o_sfr_we(swe), .o_sfr_index(sidx), .o_bank_select_field(bsel),
    .o_indirect_pointer(ptr_o));
  mmbd_sfr_model i_mmbd_sfr_model (.i_sys_clk(clk), .i_sel(ssel), .i_index(sidx),
    .o_rdata(sfr_d));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // Ram index of a location, -1 where nothing is fitted
  function automatic int ram_idx(int b, int l);
    if (l >= 'h70) return l - 'h10;
    if (b == 0 && l >= 'h20) return l - 'h20;
    return -1;
  endfunction : ram_idx
  // Program counter model beside random fetch controls
  always @(posedge clk) begin
    if (go) `CHK(pc, pc_m[12:0])
    if (go) `CHK(paddr, pc_m[10:0])
    if (rst) pc_m = 0;
    else if (ce) pc_m = intr ? 4 : br ? baddr : adv ? (pc_m + 1) % 8192 : pc_m;
    go = 1;
    rp = rnd();
    adv <= rp[0];
    br <= rp[3:1] == 0;
    intr <= rp[7:4] == 0;
    baddr <= rp[20:8];
    ce <= !rce || rp[22:21] != 0;
  end
  // One data access with its expected answer
  task automatic acc(input bit w, input bit i, input int l, input int d);
    int b, a, e;
    bit s;
    b = i ? st[7] * 2 + ptr[7] : st[6:5];
    a = i ? ptr[6:0] : l;
    s = a inside {1, 2, [5:'h1f]};
    e = a == 3 ? st : a == 4 ? ptr : s ? 'h5a ^ a : ram_idx(b, a) < 0 ? 0 : mem[ram_idx(b, a)];
    if (w && a == 3) st = d;
    else if (w && a == 4) ptr = d;
    else if (w && ram_idx(b, a) >= 0) mem[ram_idx(b, a)] = d;
    @(posedge clk);
    req <= 1; we <= w; ind <= i; daddr <= l[6:0]; wd <= d[7:0];
    @(posedge clk);
    req <= 0;
    #1;
    `CHK(rv, !w)
    `CHK(ssel, s)
    `CHK(swe, s && w)
    if (s) `CHK(sidx, a[4:0])
    repeat (2) @(posedge clk);
    #1;
    if (!w && e >= 0) `CHK(rdata, e[7:0])
  endtask : acc
  task finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    foreach (mem[k]) mem[k] = -1;
    repeat (6) @(posedge clk);
    rst <= 0;
    for (int b = 0; b < 4; b++) begin
      acc(1, 0, 3, b * 32);
      `CHK(bsel, b[1:0])
      acc(0, 0, 3, 0);
      acc(0, 0, 'h70, 0);
      acc(1, 0, 'h70, b + 'h10);
      for (int l = 1; l < 'h20; l++) if (l != 3 && l != 4) acc(l[0], 0, l, l);
      repeat (8) begin
        r = rnd();
        acc(1, 0, 'h20 + r[14:8] % 96, r[23:16]);
        acc(0, 0, 'h20 + r[14:8] % 96, 0);
        acc(0, 0, 'h20 + r[30:24] % 96, 0);
      end
    end
    // Indirect accesses through the pointer
    repeat (8) begin
      r = rnd();
      acc(1, 0, 3, {r[8], 7'h0});
      acc(1, 0, 4, r[9] * 128 + 'h20 + r[16:10] % 96);
      `CHK(ptr_o, ptr[7:0])
      acc(0, 0, 4, 0);
      acc(1, 1, r[6:0], r[31:24]);
      acc(0, 1, r[6:0] ^ 7'h55, 0);
    end
    // Clock enable freezing the counter
    rce = 1;
    repeat (64) @(posedge clk);
    rce = 0;
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    st = 0;
    ptr = 0;
    @(posedge clk);
    #1;
    `CHK(bsel, 2'b00)
    `CHK(ptr_o, 8'h00)
    finish_test();
  end
endmodule : tb_top
